/* File: pkg/rseq_params.svh */
// constants of the rail sequencer: offsets, field layouts, reset values, timing
//
// Contract
// - four status outputs report rail state; any rail may join the power-good tree.
// - output delays are 0-15 ms (one), 5-100 ms (three), 0-100 ms (two, four).
// - each status output may instead be a plain level set by software.
// - backed settings clear below lockout and load from the active bank above it.
// - every emergency shutdown reloads all backed defaults.
// - programming burns every backed setting into the nonvolatile bank.
// - event status and mask are unbacked; mask resets to ones, status from events.
// - normal address changeable, default 0x5E; programming space fixed at 0x38.
// - a burned bit only goes 0 to 1, never back.
// - a one-time pointer bit selects the second bank, irreversibly.
// - a rail enables by control pin, prior rail power-good, or software command.
// - software may enable any rail while running; clearing its bit disables only rails with no pin or power-good request.
// - six control pins form six groups; every rail is assignable to one group.
// - control three and six may act as active-low sleep, selecting the sleep code.
// - pin and prior power-good combine; both must hold to enable.
// - a programmable delay precedes assertion of a rail enable.
// - a pin raised before its prerequisite power-good waits for that power-good.
// - power-down follows pins or software with its own disable delay.
// - sleep decays or slews per decay bit; tree outputs may stay asserted.
// - below lockout tree-driven outputs drop at once; rails shut down about 444 ns later.
// - shutdown also on critical heat, optional power-good loss, optional 10 ms timeout.
// - recovery waits for supply or cooling, then reloads and resamples pins.
// - above lockout plus hysteresis, load defaults and become responsive.
// - a decaying rail keeps its power-good masked until below new overvoltage.
`ifndef RSEQ_PARAMS_SVH
`define RSEQ_PARAMS_SVH
`define RSEQ_NUM_RAILS   12
`define RSEQ_NUM_OUTS    4
`define RSEQ_NCFG        17
`define RSEQ_CLK_NS      10
`define RSEQ_MS_NS       1000000
`define RSEQ_MS_CYC      (`RSEQ_MS_NS / `RSEQ_CLK_NS)
`define RSEQ_SHDN_NS     444
`define RSEQ_SHDN_CYC    ((`RSEQ_SHDN_NS + `RSEQ_CLK_NS - 1) / `RSEQ_CLK_NS)
`define RSEQ_PGTO_MS     10
`define RSEQ_OFF_STATUS  32'h0000_0000
`define RSEQ_OFF_SWEN    32'h0000_0004
`define RSEQ_OFF_GPOMAN  32'h0000_0008
`define RSEQ_OFF_PROG    32'h0000_000C
`define RSEQ_OFF_EVT     32'h0000_0010
`define RSEQ_OFF_MASK    32'h0000_0014
`define RSEQ_OFF_PGSTAT  32'h0000_0018
`define RSEQ_OFF_ADDR    32'h0000_001C
`define RSEQ_OFF_CFG     32'h0000_0040
`define RSEQ_ADDR_RST    7'h5E
`define RSEQ_PROG_ADDR   7'h38
`define RSEQ_MASK_RST    4'hF
`define RSEQ_TREE_WMASK  32'h000F_0FFF
`define RSEQ_SHUT_WMASK  32'h0000_0003
`define RSEQ_PROG_MODE   0
`define RSEQ_PROG_BURN   1
`define RSEQ_PROG_BANK   2
`define RSEQ_PROG_PTR    3
`define RSEQ_EV_UVLO     0
`define RSEQ_EV_HOT      1
`define RSEQ_EV_PGLOSS   2
`define RSEQ_EV_PGTO     3
`define RSEQ_OUT3_MIN_MS 7'd5
`endif

/* File: pkg/rseq_pkg.sv */
// types of the rail sequencer
package rseq_pkg;
  typedef enum logic [2:0] {ST_OFF, ST_LOAD, ST_RUN, ST_DROP, ST_WAIT} rseq_state_t;
  // per-rail backed settings, one word
  typedef struct packed {
    logic [6:0] slp_vid;
    logic [6:0] vid;
    logic       decay;
    logic       slp_pin;
    logic       slp_en;
    logic [3:0] off_dly;
    logic [3:0] on_dly;
    logic [3:0] pg_sel;
    logic [2:0] ctl_sel;
  } rseq_rail_cfg_t;
  // per-output tree settings, one word
  typedef struct packed {
    logic [11:0] rsv_hi;
    logic [3:0]  dly;
    logic [3:0]  rsv_lo;
    logic [11:0] members;
  } rseq_tree_cfg_t;
  // analog side inputs
  typedef struct packed {
    logic supply_ok;
    logic supply_hys_ok;
    logic die_hot;
    logic die_cool;
  } rseq_mon_t;
endpackage

/* File: design/rseq_top.sv */
// rail sequencer with power-good tree, nonvolatile load and shutdown, AXI4-Lite slave
`include "rseq_params.svh"
module rseq_top
  import rseq_pkg::*;
#(
  parameter int NR        = `RSEQ_NUM_RAILS,
  parameter int NO        = `RSEQ_NUM_OUTS,
  parameter int MS_CYCLES = `RSEQ_MS_CYC
)(
  input  wire logic            aclk,             // system clock
  input  wire logic            aresetn,          // sync reset, low
  input  wire logic [31:0]     s_awaddr,         // write address
  input  wire logic            s_awvalid,        // write address valid
  output logic                 s_awready,        // write address ready
  input  wire logic [31:0]     s_wdata,          // write data
  input  wire logic [3:0]      s_wstrb,          // byte enables
  input  wire logic            s_wvalid,         // write data valid
  output logic                 s_wready,         // write data ready
  output logic [1:0]           s_bresp,          // write response
  output logic                 s_bvalid,         // response valid
  input  wire logic            s_bready,         // response ready
  input  wire logic [31:0]     s_araddr,         // read address
  input  wire logic            s_arvalid,        // read address valid
  output logic                 s_arready,        // read address ready
  output logic [31:0]          s_rdata,          // read data
  output logic [1:0]           s_rresp,          // read response
  output logic                 s_rvalid,         // read data valid
  input  wire logic            s_rready,         // read data ready
  input  wire logic [5:0]      control_input_n,  // six control pins, high = on
  input  wire logic [NR-1:0]   rail_power_good,  // per-rail power-good
  input  wire logic [NR-1:0]   rail_decay_busy,  // rail decaying, above new ov
  input  wire rseq_mon_t       mon,              // supply and die monitors
  output logic [NR-1:0]        rail_enable,      // internal rail enables
  output logic [NR*7-1:0]      rail_vid,         // active voltage codes
  output logic [NR-1:0]        rail_decay,       // decay instead of slew
  output logic [NO-1:0]        status_out        // status outputs one..four
);
  localparam int TW = $clog2(MS_CYCLES + 1);
  localparam logic [7:0] SHDN_N = 8'(`RSEQ_SHDN_CYC);

  rseq_state_t        state_r;
  logic [3:0]         cause_r;
  logic [31:0]        cfg_r [`RSEQ_NCFG];
  logic [31:0]        otp_r [2][`RSEQ_NCFG];
  logic               bank_ptr_r;
  logic               prog_mode_r;
  logic [NR-1:0]      sw_en_r;
  logic [7:0]         gpo_man_r;
  logic [3:0]         evt_r;
  logic [3:0]         mask_r;
  logic [6:0]         addr_r;
  logic [TW-1:0]      tick_cnt_r;
  logic               tick;
  logic [7:0]         drop_cnt_r;
  logic [3:0]         dly_cnt_r [NR];
  logic [3:0]         to_cnt_r [NR];
  logic [NR-1:0]      pg_prev_r;
  logic [6:0]         tree_cnt_r [NO];
  logic [31:0]        aw_q;
  logic [31:0]        w_q;
  logic [3:0]         ws_q;
  logic               wr_go;
  logic [31:0]        wmask;
  logic [31:0]        rd_word;
  logic               rd_ok;
  logic               wr_ok;
  logic [NR-1:0]      pg_eff;
  logic [NR-1:0]      req;
  logic [NR-1:0]      sleep_now;
  logic [3:0]         fault;
  logic [NO-1:0]      tree_all;

  // masked power-good: decaying rail is not seen as lost
  assign pg_eff = rail_power_good | rail_decay_busy;

  // per-rail request from pins, prior power-good and software
  always_comb
  begin
    for (int i = 0; i < NR; i++)
    begin
      rseq_rail_cfg_t c;
      logic ctl_ok;
      logic pg_ok;
      c = rseq_rail_cfg_t'(cfg_r[i]);
      ctl_ok = (c.ctl_sel == 3'd0) ||
               ((c.ctl_sel <= 3'd6) && control_input_n[c.ctl_sel - 3'd1]);
      pg_ok = (c.pg_sel == 4'd0) ||
              ((c.pg_sel <= 4'(NR)) && pg_eff[c.pg_sel - 4'd1]);
      req[i] = (((c.ctl_sel != 3'd0) || (c.pg_sel != 4'd0)) && ctl_ok && pg_ok)
               || sw_en_r[i];
      sleep_now[i] = c.slp_en &&
                     !(c.slp_pin ? control_input_n[5] : control_input_n[2]);
    end
  end

  // tree AND over members
  always_comb
  begin
    for (int k = 0; k < NO; k++)
    begin
      rseq_tree_cfg_t t;
      t = rseq_tree_cfg_t'(cfg_r[NR + k]);
      tree_all[k] = (t.members != 12'h000) && (&(pg_eff | ~t.members));
    end
  end

  // emergency conditions while running
  always_comb
  begin
    fault = 4'h0;
    fault[`RSEQ_EV_UVLO] = !mon.supply_ok;
    fault[`RSEQ_EV_HOT] = mon.die_hot;
    for (int i = 0; i < NR; i++)
    begin
      if (cfg_r[NR + NO][0] && rail_enable[i] && pg_prev_r[i] && !pg_eff[i])
        fault[`RSEQ_EV_PGLOSS] = 1'b1;
      if (cfg_r[NR + NO][1] && (to_cnt_r[i] >= 4'(`RSEQ_PGTO_MS)))
        fault[`RSEQ_EV_PGTO] = 1'b1;
    end
  end

  // delay of a tree output in ms; output three has a floor
  function automatic logic [6:0] tree_ms(input int k, input logic [3:0] code);
    logic [6:0] v;
    unique case (code)
      4'd0:    v = 7'd0;
      4'd1:    v = 7'd1;
      4'd2:    v = 7'd2;
      4'd3:    v = 7'd4;
      4'd4:    v = 7'd6;
      4'd5:    v = 7'd8;
      4'd6:    v = 7'd10;
      4'd7:    v = 7'd15;
      4'd8:    v = 7'd20;
      4'd9:    v = 7'd30;
      4'd10:   v = 7'd40;
      4'd11:   v = 7'd50;
      4'd12:   v = 7'd60;
      4'd13:   v = 7'd70;
      4'd14:   v = 7'd80;
      4'd15:   v = 7'd100;
    endcase
    if (k == 0)
      v = {3'b000, code};
    else if ((k == 2) && (v < `RSEQ_OUT3_MIN_MS))
      v = `RSEQ_OUT3_MIN_MS;
    return v;
  endfunction

  // one-millisecond enable pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn || (tick_cnt_r == TW'(MS_CYCLES - 1)))
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick_cnt_r + TW'(1);
  end
  assign tick = (tick_cnt_r == TW'(MS_CYCLES - 1));

  // power state machine
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= ST_OFF;
      cause_r <= 4'h0;
      drop_cnt_r <= 8'h00;
    end
    else
    begin
      unique case (state_r)
        ST_OFF:
          if (mon.supply_hys_ok)
            state_r <= ST_LOAD;
        ST_LOAD:
          state_r <= ST_RUN;
        ST_RUN:
          if (fault != 4'h0)
          begin
            state_r <= ST_DROP;
            cause_r <= fault;
            drop_cnt_r <= 8'h00;
          end
        ST_DROP:
        begin
          drop_cnt_r <= drop_cnt_r + 8'd1;
          if (!mon.supply_ok)
            cause_r[`RSEQ_EV_UVLO] <= 1'b1;
          if (drop_cnt_r >= SHDN_N - 8'd1)
            state_r <= cause_r[`RSEQ_EV_UVLO] ? ST_OFF : ST_WAIT;
        end
        ST_WAIT:
          if (!mon.supply_ok)
            state_r <= ST_OFF;
          else if (!cause_r[`RSEQ_EV_HOT] || mon.die_cool)
            state_r <= ST_LOAD;
      endcase
    end
  end

  // bus write path: address and data taken in either order
  assign wr_go = !s_awready && !s_wready && !s_bvalid;
  assign wmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
  assign wr_ok = (aw_q[31:2] <= `RSEQ_OFF_ADDR >> 2) ||
                 ((aw_q >= `RSEQ_OFF_CFG) &&
                  (aw_q < `RSEQ_OFF_CFG + 32'(4 * `RSEQ_NCFG)));
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= 2'b00;
      aw_q <= 32'h0000_0000;
      w_q <= 32'h0000_0000;
      ws_q <= 4'h0;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        aw_q <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready)
      begin
        w_q <= s_wdata;
        ws_q <= s_wstrb;
        s_wready <= 1'b0;
      end
      if (wr_go)
      begin
        s_bvalid <= 1'b1;
        s_bresp <= wr_ok ? 2'b00 : 2'b10;
      end
      if (s_bvalid && s_bready)
      begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  // read decode; unmapped answers slave error
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (s_araddr)
      `RSEQ_OFF_STATUS: rd_word = {10'h000, cause_r, bank_ptr_r,
                                   state_r != ST_RUN, status_out, rail_enable};
      `RSEQ_OFF_SWEN:   rd_word = {20'h00000, sw_en_r};
      `RSEQ_OFF_GPOMAN: rd_word = {24'h000000, gpo_man_r};
      `RSEQ_OFF_PROG:   rd_word = {28'h0000000, bank_ptr_r, 2'b00, prog_mode_r};
      `RSEQ_OFF_EVT:    rd_word = {28'h0000000, evt_r};
      `RSEQ_OFF_MASK:   rd_word = {28'h0000000, mask_r};
      `RSEQ_OFF_PGSTAT: rd_word = {20'h00000, pg_eff};
      `RSEQ_OFF_ADDR:   rd_word = {17'h00000, `RSEQ_PROG_ADDR, 1'b0, addr_r};
      default:
        if ((s_araddr >= `RSEQ_OFF_CFG) && (s_araddr[1:0] == 2'b00) &&
            (s_araddr < `RSEQ_OFF_CFG + 32'(4 * `RSEQ_NCFG)))
          rd_word = cfg_r[5'((s_araddr - `RSEQ_OFF_CFG) >> 2)];
        else
          rd_ok = 1'b0;
    endcase
  end

  // bus read path, one read outstanding
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= 2'b00;
    end
    else if (s_arvalid && s_arready)
    begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rdata <= rd_word;
      s_rresp <= rd_ok ? 2'b00 : 2'b10;
    end
    else if (s_rvalid && s_rready)
    begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // backed settings: clear, load, software write
  always_ff @(posedge aclk)
  begin
    for (int j = 0; j < `RSEQ_NCFG; j++)
    begin
      if (!aresetn || (state_r == ST_OFF))
        cfg_r[j] <= 32'h0000_0000;
      else if (state_r == ST_LOAD)
        cfg_r[j] <= otp_r[bank_ptr_r][j];
      else if (wr_go && (aw_q == `RSEQ_OFF_CFG + 32'(4 * j)))
        cfg_r[j] <= ((cfg_r[j] & ~wmask) | (w_q & wmask)) &
                    ((j < NR) ? 32'hFFFF_FFFF :
                     (j < NR + NO) ? `RSEQ_TREE_WMASK : `RSEQ_SHUT_WMASK);
    end
  end

  // nonvolatile banks: burning can only set bits; the pointer only moves forward
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bank_ptr_r <= 1'b0;
      for (int b = 0; b < 2; b++)
        for (int j = 0; j < `RSEQ_NCFG; j++)
          otp_r[b][j] <= 32'h0000_0000;
    end
    else if (wr_go && prog_mode_r && (aw_q == `RSEQ_OFF_PROG) && ws_q[0])
    begin
      if (w_q[`RSEQ_PROG_BURN])
        for (int j = 0; j < `RSEQ_NCFG; j++)
          otp_r[bank_ptr_r][j] <= otp_r[bank_ptr_r][j] | cfg_r[j];
      if (w_q[`RSEQ_PROG_BANK])
        bank_ptr_r <= 1'b1;
    end
  end

  // unbacked control registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sw_en_r <= '0;
      gpo_man_r <= 8'h00;
      prog_mode_r <= 1'b0;
      mask_r <= `RSEQ_MASK_RST;
      addr_r <= `RSEQ_ADDR_RST;
    end
    else
    begin
      if (state_r != ST_RUN)
        sw_en_r <= '0;
      else if (wr_go && (aw_q == `RSEQ_OFF_SWEN))
        sw_en_r <= NR'((32'(sw_en_r) & ~wmask) | (w_q & wmask));
      if (wr_go && (aw_q == `RSEQ_OFF_GPOMAN) && ws_q[0])
        gpo_man_r <= w_q[7:0];
      if (wr_go && (aw_q == `RSEQ_OFF_PROG) && ws_q[0])
        prog_mode_r <= w_q[`RSEQ_PROG_MODE];
      if (wr_go && (aw_q == `RSEQ_OFF_MASK) && ws_q[0])
        mask_r <= w_q[3:0];
      if (wr_go && (aw_q == `RSEQ_OFF_ADDR) && ws_q[0])
        addr_r <= w_q[6:0];
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      evt_r <= 4'h0;
    else
      evt_r <= (evt_r & ~((wr_go && (aw_q == `RSEQ_OFF_EVT) && ws_q[0]) ? w_q[3:0] : 4'h0))
               | ((state_r == ST_RUN) ? fault : 4'h0);
  end

  // rail enables with separate on and off delays in ms ticks
  always_ff @(posedge aclk)
  begin
    for (int i = 0; i < NR; i++)
    begin
      rseq_rail_cfg_t c;
      c = rseq_rail_cfg_t'(cfg_r[i]);
      if (!aresetn || (state_r == ST_OFF) || (state_r == ST_LOAD) ||
          (state_r == ST_WAIT) || ((state_r == ST_DROP) && (drop_cnt_r >= SHDN_N - 8'd1)))
      begin
        rail_enable[i] <= 1'b0;
        dly_cnt_r[i] <= 4'h0;
      end
      else if ((state_r == ST_RUN) && (req[i] != rail_enable[i]))
      begin
        if (dly_cnt_r[i] >= (req[i] ? c.on_dly : c.off_dly))
        begin
          rail_enable[i] <= req[i];
          dly_cnt_r[i] <= 4'h0;
        end
        else if (tick)
          dly_cnt_r[i] <= dly_cnt_r[i] + 4'd1;
      end
      else
        dly_cnt_r[i] <= 4'h0;
    end
  end

  // voltage code and decay choice per rail
  always_ff @(posedge aclk)
  begin
    for (int i = 0; i < NR; i++)
    begin
      rseq_rail_cfg_t c;
      c = rseq_rail_cfg_t'(cfg_r[i]);
      if (!aresetn)
      begin
        rail_vid[i*7 +: 7] <= 7'h00;
        rail_decay[i] <= 1'b0;
      end
      else
      begin
        rail_vid[i*7 +: 7] <= sleep_now[i] ? c.slp_vid : c.vid;
        rail_decay[i] <= c.decay;
      end
    end
  end

  // power-good loss and 10 ms timeout watch
  always_ff @(posedge aclk)
  begin
    for (int i = 0; i < NR; i++)
    begin
      if (!aresetn || (state_r != ST_RUN))
      begin
        pg_prev_r[i] <= 1'b0;
        to_cnt_r[i] <= 4'h0;
      end
      else
      begin
        pg_prev_r[i] <= rail_enable[i] && pg_eff[i];
        if (!rail_enable[i] || pg_eff[i])
          to_cnt_r[i] <= 4'h0;
        else if (tick && (to_cnt_r[i] < 4'(`RSEQ_PGTO_MS)))
          to_cnt_r[i] <= to_cnt_r[i] + 4'd1;
      end
    end
  end

  // status outputs: tree with delay, or software level; sleep leaves them alone
  always_ff @(posedge aclk)
  begin
    for (int k = 0; k < NO; k++)
    begin
      rseq_tree_cfg_t t;
      t = rseq_tree_cfg_t'(cfg_r[NR + k]);
      if (!aresetn)
      begin
        status_out[k] <= 1'b0;
        tree_cnt_r[k] <= 7'h00;
      end
      else if (gpo_man_r[k])
      begin
        status_out[k] <= gpo_man_r[4 + k];
        tree_cnt_r[k] <= 7'h00;
      end
      else if ((state_r != ST_RUN) || (fault != 4'h0) || !tree_all[k])
      begin
        status_out[k] <= 1'b0;
        tree_cnt_r[k] <= 7'h00;
      end
      else if (tree_cnt_r[k] >= tree_ms(k, t.dly))
        status_out[k] <= 1'b1;
      else if (tick)
        tree_cnt_r[k] <= tree_cnt_r[k] + 7'd1;
    end
  end
endmodule

/* File: testbench/rseq_rail_model.sv */
// board-side rail model: each rail ramps and reports power-good after a fixed delay
module rseq_rail_model
#(
  parameter int NR     = 12,
  parameter int PG_DLY = 4
)(
  input  wire logic [0:0]    aclk,            // system clock
  input  wire logic [NR-1:0] rail_enable,     // enables from the block
  output logic      [NR-1:0] rail_power_good  // power-good back to the block
);
  logic [NR-1:0] ramp_r [PG_DLY];

  // ramp and decay both take PG_DLY cycles, so power-good never beats the enable
  always_ff @(posedge aclk)
  begin
    ramp_r[0] <= rail_enable;
    for (int i = 1; i < PG_DLY; i++)
      ramp_r[i] <= ramp_r[i-1];
  end

  // last ramp stage is the reported level
  assign rail_power_good = ramp_r[PG_DLY-1];
endmodule

/* File: testbench/rseq_top_props.sv */
// concurrent checks on the rail sequencer ports, bound into the top module
module rseq_top_props
  import rseq_pkg::*;
#(
  parameter int NR = 12
)(
  input wire logic          aclk,        // system clock
  input wire logic          aresetn,     // sync reset, low
  input wire logic          s_awvalid,   // write address valid
  input wire logic          s_awready,   // write address ready
  input wire logic          s_wvalid,    // write data valid
  input wire logic          s_wready,    // write data ready
  input wire logic          s_bvalid,    // write response valid
  input wire logic          s_arvalid,   // read address valid
  input wire logic          s_arready,   // read address ready
  input wire logic          s_rvalid,    // read data valid
  input wire rseq_mon_t     mon,         // supply and die monitors
  input wire logic [NR-1:0] rail_enable  // rail enables
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // bus answers and one-at-a-time readiness
  property p_rd_ans;
    s_arvalid && s_arready |=> s_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_busy;
    s_rvalid |-> !s_arready;
  endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("read taken while busy");
  property p_wr_ans;
    s_awvalid && s_awready && s_wvalid && s_wready |-> ##[1:2] s_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
  property p_wr_busy;
    s_bvalid |-> !s_awready && !s_wready;
  endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write taken while busy");

  // shutdown: rails hold briefly, then all drop about 45 cycles on
  property p_uvlo_hold;
    $fell(mon.supply_ok) && (|rail_enable) |=> (|rail_enable) [*8];
  endproperty
  a_uvlo_hold: assert property (p_uvlo_hold) else $error("rails dropped early");
  property p_uvlo_off;
    $fell(mon.supply_ok) && (|rail_enable) |-> ##[40:50] (rail_enable == '0);
  endproperty
  a_uvlo_off: assert property (p_uvlo_off) else $error("rails not shut on lockout");
  property p_hot_off;
    $rose(mon.die_hot) && (|rail_enable) |-> ##[40:50] (rail_enable == '0);
  endproperty
  a_hot_off: assert property (p_hot_off) else $error("rails not shut on heat");
  // two low samples so the fault edge itself cannot race an enable
  property p_off_stay;
    !mon.supply_ok && !$past(mon.supply_ok) && (rail_enable == '0) |=> (rail_enable == '0);
  endproperty
  a_off_stay: assert property (p_off_stay) else $error("rail on below lockout");
endmodule

bind rseq_top rseq_top_props #(.NR(NR)) u_props (.aclk(aclk), .aresetn(aresetn),
  .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready),
  .s_bvalid(s_bvalid), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid),
  .mon(mon), .rail_enable(rail_enable));

/* File: testbench/tb.sv */
// self-checking bench: registers, sequencing, power-good tree, reload and shutdown
module tb
  import rseq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [31:0] s_awaddr, s_wdata, s_araddr, s_rdata, rd;
  logic [1:0]  s_bresp, s_rresp, rr;
  logic [3:0]  s_wstrb, status_out;
  logic [5:0]  control_input_n;
  logic [11:0] rail_power_good, rail_decay_busy, rail_enable, rail_decay;
  logic [83:0] rail_vid;
  logic [15:0] obs;
  rseq_mon_t   mon;
  int          mismatches, checks, n;

  // one vector so a single wait task serves rails and status outputs
  assign obs = {status_out, rail_enable};

  // 100 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // short ms tick keeps the ms delays cheap to simulate
  rseq_top #(.MS_CYCLES(20)) dut (.*);
  rseq_rail_model #(.NR(12)) u_rails (.aclk(aclk), .rail_enable(rail_enable),
    .rail_power_good(rail_power_good));

  // verdict
  task end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  // count edges until an observed bit reaches a level
  task wait_bit(input int i, input logic v, output int c);
    c = 0;
    while (obs[i] !== v)
    begin
      @(posedge aclk);
      c++;
    end
  endtask

  // bus write: address and data offered together, each dropped once taken
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_awaddr  <= 32'(a);
    s_wdata   <= d;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_awready === 1'b1)
        s_awvalid <= 1'b0;
      if (s_wready === 1'b1)
        s_wvalid <= 1'b0;
      if (s_bvalid === 1'b1)
      begin
        rr = s_bresp;
        s_bready <= 1'b0;
        break;
      end
    end
  endtask

  // bus read
  task axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_araddr  <= 32'(a);
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_arready === 1'b1)
        s_arvalid <= 1'b0;
      if (s_rvalid === 1'b1)
      begin
        rd = s_rdata;
        rr = s_rresp;
        s_rready <= 1'b0;
        break;
      end
    end
  endtask

  // unbacked defaults, address register, unmapped access
  task t_regs;
    axi_rd(8'h14); chk(rd, 32'h0000_000F);
    axi_rd(8'h10); chk(rd, 32'h0000_0000);
    axi_rd(8'h1C); chk(rd, 32'h0000_385E);
    axi_wr(8'h1C, 32'h0000_0011); chk(32'(rr), 32'h0000_0000);
    axi_rd(8'h1C); chk(rd, 32'h0000_3811);
    axi_rd(8'h3C); chk(32'(rr), 32'h0000_0002);
    axi_wr(8'h3C, 32'h0000_0001); chk(32'(rr), 32'h0000_0002);
  endtask

  // pin one starts rail 0, rail 1 needs pin two and rail 0 power-good, tree on both
  task t_seq;
    axi_wr(8'h40, 32'h2082_9901);
    axi_wr(8'h44, 32'h0000_000A);
    axi_wr(8'h70, 32'h0002_0003);
    cyc(3); chk(32'(rail_vid[6:0]), 32'h0000_0010);
    chk(32'(rail_decay[0]), 32'h0000_0001);
    @(posedge aclk);
    control_input_n <= 6'h07;
    cyc(3); chk(32'(rail_vid[6:0]), 32'h0000_0020);
    cyc(12); chk(32'(rail_enable[1:0]), 32'h0000_0000);
    wait_bit(0, 1'b1, n); chk(32'(n >= 3 && n <= 30), 32'h0000_0001);
    chk(32'(rail_enable[1]), 32'h0000_0000);
    wait_bit(1, 1'b1, n); chk(32'(n >= 4 && n <= 8), 32'h0000_0001);
    wait_bit(12, 1'b1, n); chk(32'(n >= 20 && n <= 52), 32'h0000_0001);
    control_input_n <= 6'h06;
    wait_bit(0, 1'b0, n); chk(32'(n >= 38 && n <= 66), 32'h0000_0001);
    wait_bit(12, 1'b0, n); chk(32'(n >= 3 && n <= 7), 32'h0000_0001);
  endtask

  // software enable and manual status level
  task t_sw;
    axi_wr(8'h04, 32'h0000_0020); cyc(3); chk(32'(rail_enable[5]), 32'h0000_0001);
    axi_wr(8'h08, 32'h0000_0022); cyc(2); chk(32'(status_out[1]), 32'h0000_0001);
    axi_wr(8'h08, 32'h0000_0002); cyc(2); chk(32'(status_out[1]), 32'h0000_0000);
    axi_wr(8'h08, 32'h0000_0000);
    // a decaying rail must read as good even with its power-good low
    rail_decay_busy <= 12'h800;
    axi_rd(8'h18); chk(rd, 32'h0000_0820);
    rail_decay_busy <= '0;
  endtask

  // two burns accumulate, lockout clears and reloads
  task t_otp;
    axi_wr(8'h0C, 32'h0000_0001); axi_wr(8'h48, 32'h0000_0110);
    axi_wr(8'h0C, 32'h0000_0003); axi_wr(8'h48, 32'h0000_0201);
    axi_wr(8'h0C, 32'h0000_0003); axi_wr(8'h48, 32'h0000_0000);
    @(posedge aclk);
    mon.supply_ok     <= 1'b0;
    mon.supply_hys_ok <= 1'b0;
    cyc(60); chk(32'(obs), 32'h0000_0000);
    axi_rd(8'h48); chk(rd, 32'h0000_0000);
    axi_rd(8'h10); chk(32'(rd[0]), 32'h0000_0001);
    axi_wr(8'h10, 32'h0000_000F); axi_rd(8'h10); chk(rd, 32'h0000_0000);
    mon.supply_ok     <= 1'b1;
    mon.supply_hys_ok <= 1'b1;
    cyc(5); axi_rd(8'h48); chk(rd, 32'h0000_0311);
    axi_rd(8'h40); chk(rd, 32'h2082_9901);
  endtask

  // bank move, heat shutdown, recovery only after cooling
  task t_bank;
    axi_wr(8'h04, 32'h0000_0020); axi_wr(8'h0C, 32'h0000_0005);
    axi_rd(8'h0C); chk(32'(rd[3]), 32'h0000_0001);
    @(posedge aclk);
    mon.die_hot  <= 1'b1;
    mon.die_cool <= 1'b0;
    cyc(60); chk(32'(rail_enable), 32'h0000_0000);
    mon.die_hot <= 1'b0;
    cyc(20); axi_rd(8'h00); chk(32'(rd[17:16]), 32'h0000_0003);
    mon.die_cool <= 1'b1;
    cyc(5); axi_rd(8'h40); chk(rd, 32'h0000_0000);
    axi_rd(8'h00); chk(32'(rd[17:16]), 32'h0000_0002);
  endtask

  // main sequence
  initial
  begin
    aresetn         = 1'b0;
    s_awvalid       = 1'b0;
    s_wvalid        = 1'b0;
    s_bready        = 1'b0;
    s_arvalid       = 1'b0;
    s_rready        = 1'b0;
    s_awaddr        = '0;
    s_wdata         = '0;
    s_araddr        = '0;
    s_wstrb         = 4'hF;
    control_input_n = '0;
    rail_decay_busy = '0;
    mon             = 4'hD;
    mismatches      = 0;
    checks          = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(3);
    t_regs;
    t_seq;
    t_sw;
    t_otp;
    t_bank;
    end_of_test;
  end

  // hang guard, well beyond the few hundred cycles the run needs
  initial
  begin
    #200000;
    mismatches++;
    end_of_test;
  end
endmodule
